// ==== rtl/hwo_defines.svh ====
/*
 Register map, field positions, reset values and timing constants of the
 host-watchdog and output-safety block. Assumes inclusion by bare name.
*/
`ifndef HWO_DEFINES_SVH
`define HWO_DEFINES_SVH

// Register byte addresses on APB
`define HWO_A_CMD    8'h00
`define HWO_A_ARG    8'h04
`define HWO_A_REPLY  8'h08
`define HWO_A_RDATA  8'h0c
`define HWO_A_STAT   8'h10
`define HWO_A_CFG    8'h14
`define HWO_A_ECFG   8'h18
`define HWO_A_DOUT   8'h1c
`define HWO_A_KICK   8'h20
`define HWO_A_DIN    8'h24

// Command register fields
`define HWO_CMD_OP   3:0
`define HWO_CMD_EN   4
`define HWO_CMD_CERR 5
`define HWO_CMD_BAD  6
`define HWO_CMD_PER  15:8

// Reply register fields
`define HWO_RPL_KIND 1:0
`define HWO_RPL_RDY  2
`define HWO_RPL_BUSY 3
`define HWO_RPL_ADDR 15:8

// Status register fields
`define HWO_ST_CODE  7:0
`define HWO_ST_WDEN  8
`define HWO_ST_ALARM 9
`define HWO_ST_RSTF  10
`define HWO_ST_STRAP 11
`define HWO_ST_PER   23:16

// Configuration register fields
`define HWO_CFG_ADDR 7:0
`define HWO_CFG_BAUD 15:8
`define HWO_CFG_CHK  16

// Status codes
`define HWO_CODE_NORMAL 8'h00
`define HWO_CODE_ALARM  8'h04

// Strapped default configuration (baud code 06 means 9600)
`define HWO_DEF_ADDR 8'h00
`define HWO_DEF_BAUD 8'h06
`define HWO_DEF_CHK  1'b0

// Reset values of the stored settings
`define HWO_RST_PON   8'h00
`define HWO_RST_SAFE  8'h00
`define HWO_RST_NAME  32'h3f3f3f3f
`define HWO_RST_ADDR  8'h01
`define HWO_RST_BAUD  8'h06
`define HWO_RST_PER   8'h00

// Timing: tick of 0.1 s, module watchdog preset time
`define HWO_CLK_MHZ   100
`define HWO_TICK_MS   100
`define HWO_TICK_CYC  (`HWO_TICK_MS * 1000 * `HWO_CLK_MHZ)
`define HWO_MWD_MS    500
`define HWO_MWD_CYC   (`HWO_MWD_MS * 1000 * `HWO_CLK_MHZ)

`endif

// ==== rtl/hwo_host_wd.sv ====
/*
 Host watchdog timer: divides the clock to a 0.1 s tick and counts ticks
 since the last host-alive kick; gives one expiry pulse per silence.
 Assumes enable and period come from flops of the command handler.
*/
`timescale 1ns/1ns
`default_nettype none
`include "hwo_defines.svh"

module hwo_host_wd #(
	parameter int TICK_CYC = `HWO_TICK_CYC   // Cycles per 0.1 s tick
) (
	input  wire logic       pclk,     // Clock
	input  wire logic       presetn,  // Async reset, active low
	input  wire logic       enable,   // Watchdog enabled
	input  wire logic [7:0] period,   // Period in tenths of a second
	input  wire logic       kick,     // Host-alive pulse
	output logic            expire    // One-cycle expiry pulse
);
	import hwo_pkg::*;

	hwo_wd_t q;
	hwo_wd_t d;

	// Tick divider and silence counter; a kick or disable restarts all
	always_comb begin
		d = q;
		d.expire = 1'b0;
		if (kick || !enable) begin // RULE7 RULE26
			d.div = '0;
			d.cnt = '0;
			d.fired = 1'b0;
		end else begin
			if (q.div == 32'(TICK_CYC - 1)) begin // RULE5
				d.div = '0;
				if (q.cnt != 8'hff)
					d.cnt = q.cnt + 8'h01; // Saturates, never wraps
			end else begin
				d.div = q.div + 32'h1;
			end
			// Period zero never fires; a lowered period fires at once
			if (!q.fired && period != 8'h00 && q.cnt >= period) begin // RULE8
				d.expire = 1'b1;
				d.fired = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			q <= '0;
		else
			q <= d;
	end

	assign expire = q.expire;

	kick_restart_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		kick |=> (q.cnt == 8'h00 && q.div == 32'h0 && !expire))
		else $error("kick did not restart the host watchdog");

	tick_spacing_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
		($changed(q.cnt) && q.cnt != 8'h00) |-> $past(q.div) == 32'(TICK_CYC - 1))
		else $error("tick count advanced off the 0.1 s boundary");

	expire_due_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		expire |-> $past(enable) && !$past(kick) && $past(q.cnt) >= $past(period))
		else $error("expiry before the programmed period");

endmodule
`default_nettype wire

// ==== rtl/hwo_pkg.sv ====
/*
 Types of the host-watchdog and output-safety block: states, commands,
 reply kinds and the state records of both modules. Needs hwo_defines.svh
 nowhere; pure type definitions.
*/
package hwo_pkg;

	// Command handler states, one-hot
	typedef enum logic [1:0] {
		HWO_S_IDLE = 2'h1,
		HWO_S_EXEC = 2'h2
	} hwo_fsm_t;

	// Decoded command codes posted by the line front end
	typedef enum logic [3:0] {
		HWO_OP_NONE           = 4'h0,
		HWO_OP_STATUS_READ    = 4'h1,
		HWO_OP_STATUS_RESET   = 4'h2,
		HWO_OP_WD_READ        = 4'h3,
		HWO_OP_WD_ENABLE      = 4'h4,
		HWO_OP_PON_READ       = 4'h5,
		HWO_OP_SAFE_READ      = 4'h6,
		HWO_OP_PON_CAPTURE    = 4'h7,
		HWO_OP_SAFE_CAPTURE   = 4'h8,
		HWO_OP_NAME_SET       = 4'h9,
		HWO_OP_NAME_READ      = 4'ha,
		HWO_OP_RESET_READBACK = 4'hb,
		HWO_OP_CONFIG_READ    = 4'hc,
		HWO_OP_HOST_ALIVE     = 4'hd
	} hwo_op_t;

	// Reply kinds: none, valid (address first), invalid
	typedef enum logic [1:0] {
		HWO_RK_NONE    = 2'h0,
		HWO_RK_VALID   = 2'h1,
		HWO_RK_INVALID = 2'h2
	} hwo_rkind_t;

	// Whole state of the top module
	typedef struct packed {
		hwo_fsm_t   fsm;
		hwo_op_t    op;
		logic       arg_en;
		logic [7:0] arg_per;
		logic       err_comm;
		logic       err_bad;
		logic [31:0] name_arg;
		logic       wd_en;
		logic [7:0] wd_per;
		logic       alarm;
		logic [7:0] pon;
		logic [7:0] safe;
		logic [31:0] name;
		logic [7:0] cfg_addr;
		logic [7:0] cfg_baud;
		logic       cfg_chk;
		logic [7:0] eff_addr;
		logic [7:0] eff_baud;
		logic       eff_chk;
		logic       strap;
		logic       strap_done;
		logic       rst_flag;
		logic [7:0] dout;
		logic [7:0] din;
		logic [31:0] mwd_cnt;
		logic       cpu_rst;
		logic       kick;
		hwo_rkind_t rkind;
		logic       rready;
		logic [31:0] rdata;
		logic       pready;
		logic       pslverr;
		logic [31:0] prdata;
	} hwo_state_t;

	// Whole state of the host watchdog timer
	typedef struct packed {
		logic [31:0] div;
		logic [7:0]  cnt;
		logic        fired;
		logic        expire;
	} hwo_wd_t;

endpackage

// ==== rtl/hwo_top.sv ====
/*
 Command handling and supervision of a remote digital I/O module: host
 watchdog with alarm status, stored power-on and safe output bytes, module
 name, default-configuration strap and internal module watchdog.
 Assumes a line front end that parses each framed command, posts it over
 APB into the command register and sends the reply built here.
*/
//
// Contract
// RULE1: alarm sets status code 04 and holds
// RULE2: status-reset clears code; acked; errors handled
// RULE3: watchdog read returns address, enable, period
// RULE4: watchdog enable stores flag and period; acked
// RULE5: period counts in tenths of a second
// RULE6: host broadcasts host-alive before period ends
// RULE7: host-alive clears and restarts watchdog timer
// RULE8: silence longer than period raises alarm
// RULE9: alarm forces outputs to safe byte
// RULE10: power-on read returns byte then zeros
// RULE11: safe read returns byte then zeros
// RULE12: power-on capture copies present outputs
// RULE13: safe capture copies present outputs
// RULE14: power-up forces outputs to power-on byte
// RULE15: name set stores four characters for read
// RULE16: grounded strap forces address 00, 9600, nochecksum
// RULE17: stored configuration still reported, used next power-up
// RULE18: closed contact reads one, open reads zero
// RULE19: module watchdog restarts processor when unrefreshed
// RULE20: module watchdog reset restores default outputs
// RULE21: host resends outputs after detecting reset
// RULE22: reset readback reports one after reset
// RULE23: status read gives 00 normal, 04 alarm
// RULE24: host-alive gets no reply
// RULE25: reset flag reads one after power-up
// RULE26: disabled watchdog never raises alarm
`timescale 1ns/1ns
`default_nettype none
`include "hwo_defines.svh"

module hwo_top #(
	parameter int NIN      = 8,               // Digital input channels, up to 8
	parameter bit HAS_OUT  = 1'b1,            // Variant has digital outputs
	parameter int TICK_CYC = `HWO_TICK_CYC,   // Cycles per 0.1 s tick
	parameter int MWD_CYC  = `HWO_MWD_CYC     // Module watchdog preset, cycles
) (
	input  wire logic           pclk,              // Clock, 100 MHz
	input  wire logic           presetn,           // Async reset, active low
	input  wire logic           psel,              // APB select
	input  wire logic           penable,           // APB access phase
	input  wire logic           pwrite,            // APB write
	input  wire logic [7:0]     paddr,             // APB byte address
	input  wire logic [31:0]    pwdata,            // APB write data
	output logic [31:0]         prdata,            // APB read data
	output logic                pready,            // APB ready
	output logic                pslverr,           // APB error
	input  wire logic [NIN-1:0] input_channel_pin, // Inputs, low when closed
	input  wire logic           init_strap_n,      // Strap, low forces defaults
	output logic [7:0]          digital_out,       // Digital output byte
	output logic                cpu_reset_pulse,   // Module watchdog restart
	output logic [7:0]          eff_addr,          // Address in use
	output logic [7:0]          eff_baud,          // Baud code in use
	output logic                eff_chk,           // Checksum in use
	output logic                alarm_out          // Host watchdog alarm
);
	import hwo_pkg::*;

	hwo_state_t q;
	hwo_state_t d;
	logic       expire_w;
	logic [7:0] din_w;

	// A grounded input pin means a closed contact, so each channel bit inverts; bits above NIN read zero
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_din
			if (gi < NIN) begin : g_on
				assign din_w[gi] = ~input_channel_pin[gi]; // RULE18
			end else begin : g_off
				assign din_w[gi] = 1'b0;
			end
		end
	endgenerate

	// Host watchdog timer on the 0.1 s tick
	hwo_host_wd #(
		.TICK_CYC (TICK_CYC)
	) u_wd (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (q.wd_en),
		.period  (q.wd_per),
		.kick    (q.kick),
		.expire  (expire_w)
	);

	// Bus, command execution and supervision; later steps win, so events
	// that set a flag override a clear in the same cycle
	always_comb begin
		logic [31:0] rd;
		logic        hit;
		logic [7:0]  code;
		rd = '0;
		hit = 1'b1;
		code = q.alarm ? `HWO_CODE_ALARM : `HWO_CODE_NORMAL; // RULE1 RULE23
		d = q;
		d.kick = 1'b0;
		d.cpu_rst = 1'b0;
		d.din = din_w;

		// Strap caught once after power-up; stored values stay readable
		if (!q.strap_done) begin // RULE16 RULE17
			d.strap_done = 1'b1;
			d.strap = !init_strap_n;
			d.eff_addr = init_strap_n ? q.cfg_addr : `HWO_DEF_ADDR;
			d.eff_baud = init_strap_n ? q.cfg_baud : `HWO_DEF_BAUD;
			d.eff_chk = init_strap_n ? q.cfg_chk : `HWO_DEF_CHK;
		end

		// Read mux; one wait state lets prdata come from a flop
		case (paddr)
			`HWO_A_CMD: begin
				rd[`HWO_CMD_OP] = q.op;
				rd[`HWO_CMD_EN] = q.arg_en;
				rd[`HWO_CMD_CERR] = q.err_comm;
				rd[`HWO_CMD_BAD] = q.err_bad;
				rd[`HWO_CMD_PER] = q.arg_per;
			end
			`HWO_A_ARG:   rd = q.name_arg;
			`HWO_A_REPLY: begin
				rd[`HWO_RPL_KIND] = q.rkind;
				rd[`HWO_RPL_RDY] = q.rready;
				rd[`HWO_RPL_BUSY] = (q.fsm == HWO_S_EXEC);
				rd[`HWO_RPL_ADDR] = q.eff_addr;
			end
			`HWO_A_RDATA: rd = q.rdata;
			`HWO_A_STAT: begin
				rd[`HWO_ST_CODE] = code;
				rd[`HWO_ST_WDEN] = q.wd_en;
				rd[`HWO_ST_ALARM] = q.alarm;
				rd[`HWO_ST_RSTF] = q.rst_flag;
				rd[`HWO_ST_STRAP] = q.strap;
				rd[`HWO_ST_PER] = q.wd_per;
			end
			`HWO_A_CFG: begin
				rd[`HWO_CFG_ADDR] = q.cfg_addr;
				rd[`HWO_CFG_BAUD] = q.cfg_baud;
				rd[`HWO_CFG_CHK] = q.cfg_chk;
			end
			`HWO_A_ECFG: begin
				rd[`HWO_CFG_ADDR] = q.eff_addr;
				rd[`HWO_CFG_BAUD] = q.eff_baud;
				rd[`HWO_CFG_CHK] = q.eff_chk;
			end
			`HWO_A_DOUT:  rd[7:0] = q.dout;
			`HWO_A_KICK:  rd = '0;
			`HWO_A_DIN:   rd[7:0] = q.din;
			default:      hit = 1'b0;
		endcase

		// APB answer: ready rises in the second access cycle, drops the next
		d.pready = psel && penable && !q.pready;
		if (psel && penable && !q.pready) begin
			d.prdata = rd;
			d.pslverr = !hit;
		end

		// Module watchdog counts unless the processor refreshes it
		d.mwd_cnt = q.mwd_cnt + 32'h1;

		// Writes take effect at the completing edge only
		if (psel && penable && q.pready && pwrite && hit) begin
			case (paddr)
				`HWO_A_CMD: begin
					// A command posted while one runs is dropped
					if (q.fsm == HWO_S_IDLE) begin
						d.op = hwo_op_t'(pwdata[`HWO_CMD_OP]);
						d.arg_en = pwdata[`HWO_CMD_EN];
						d.err_comm = pwdata[`HWO_CMD_CERR];
						d.err_bad = pwdata[`HWO_CMD_BAD];
						d.arg_per = pwdata[`HWO_CMD_PER];
						d.rready = 1'b0;
						d.fsm = HWO_S_EXEC;
					end
				end
				`HWO_A_ARG:  d.name_arg = pwdata;
				`HWO_A_CFG: begin
					d.cfg_addr = pwdata[`HWO_CFG_ADDR];
					d.cfg_baud = pwdata[`HWO_CFG_BAUD];
					d.cfg_chk = pwdata[`HWO_CFG_CHK];
				end
				`HWO_A_DOUT: d.dout = HAS_OUT ? pwdata[7:0] : 8'h00;
				`HWO_A_KICK: d.mwd_cnt = '0;
				default: ;
			endcase
		end

		// Command execution, one cycle
		if (q.fsm == HWO_S_EXEC) begin
			d.fsm = HWO_S_IDLE;
			d.rready = 1'b1;
			d.rkind = HWO_RK_VALID;
			d.rdata = '0;
			if (q.err_comm) begin
				d.rkind = HWO_RK_NONE; // RULE2
			end else if (q.err_bad) begin
				d.rkind = HWO_RK_INVALID; // RULE2
			end else begin
				case (q.op)
					HWO_OP_STATUS_READ:  d.rdata[7:0] = code; // RULE23
					HWO_OP_STATUS_RESET: d.alarm = 1'b0; // RULE2
					HWO_OP_WD_READ: begin
						d.rdata[8] = q.wd_en; // RULE3
						d.rdata[7:0] = q.wd_per;
					end
					HWO_OP_WD_ENABLE: begin
						d.wd_en = q.arg_en; // RULE4
						d.wd_per = q.arg_per;
					end
					HWO_OP_PON_READ: begin
						if (HAS_OUT)
							d.rdata[15:8] = q.pon; // RULE10
						else
							d.rkind = HWO_RK_INVALID;
					end
					HWO_OP_SAFE_READ: begin
						if (HAS_OUT)
							d.rdata[15:8] = q.safe; // RULE11
						else
							d.rkind = HWO_RK_INVALID;
					end
					HWO_OP_PON_CAPTURE: begin
						if (HAS_OUT)
							d.pon = q.dout; // RULE12
						else
							d.rkind = HWO_RK_INVALID;
					end
					HWO_OP_SAFE_CAPTURE: begin
						if (HAS_OUT)
							d.safe = q.dout; // RULE13
						else
							d.rkind = HWO_RK_INVALID;
					end
					HWO_OP_NAME_SET:     d.name = q.name_arg; // RULE15
					HWO_OP_NAME_READ:    d.rdata = q.name; // RULE15
					HWO_OP_RESET_READBACK: begin
						d.rdata[0] = q.rst_flag; // RULE22
						d.rst_flag = 1'b0;
					end
					HWO_OP_CONFIG_READ: begin
						d.rdata[`HWO_CFG_ADDR] = q.cfg_addr; // RULE17
						d.rdata[`HWO_CFG_BAUD] = q.cfg_baud;
						d.rdata[`HWO_CFG_CHK] = q.cfg_chk;
					end
					HWO_OP_HOST_ALIVE: begin
						d.kick = 1'b1; // RULE6 RULE7
						d.rkind = HWO_RK_NONE; // RULE24
					end
					default:             d.rkind = HWO_RK_INVALID;
				endcase
			end
		end

		// Module watchdog expiry restarts the processor, outputs to default
		if (q.mwd_cnt == 32'(MWD_CYC - 1)) begin // RULE19
			d.mwd_cnt = '0;
			d.cpu_rst = 1'b1;
			d.rst_flag = 1'b1; // RULE22
			d.dout = q.pon; // RULE20
		end

		// Host watchdog alarm wins over a clear and over an output write
		if (expire_w) begin
			d.alarm = 1'b1; // RULE1
			d.dout = HAS_OUT ? q.safe : 8'h00; // RULE9
		end
	end

	// State register; power-up drives outputs to the power-on byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.fsm <= HWO_S_IDLE;
			q.rst_flag <= 1'b1; // RULE25
			q.dout <= `HWO_RST_PON; // RULE14
			q.pon <= `HWO_RST_PON;
			q.safe <= `HWO_RST_SAFE;
			q.name <= `HWO_RST_NAME;
			q.wd_per <= `HWO_RST_PER;
			q.cfg_addr <= `HWO_RST_ADDR;
			q.cfg_baud <= `HWO_RST_BAUD;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign digital_out = q.dout;
	assign cpu_reset_pulse = q.cpu_rst;
	assign eff_addr = q.eff_addr;
	assign eff_baud = q.eff_baud;
	assign eff_chk = q.eff_chk;
	assign alarm_out = q.alarm;

	// Execution of a well-formed command, for the checks below
	logic exec_w;
	assign exec_w = (q.fsm == HWO_S_EXEC) && !q.err_comm && !q.err_bad;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	alarm_hold_a: assert property ( // RULE1
		(q.alarm && !(exec_w && q.op == HWO_OP_STATUS_RESET)) |=> q.alarm)
		else $error("alarm dropped without status reset");

	status_clear_a: assert property ( // RULE2
		(exec_w && q.op == HWO_OP_STATUS_RESET && !expire_w) |=>
		(!q.alarm && q.rkind == HWO_RK_VALID && q.rready))
		else $error("status reset did not clear the alarm");

	wd_store_a: assert property ( // RULE4
		(exec_w && q.op == HWO_OP_WD_ENABLE) |=>
		(q.wd_en == $past(q.arg_en) && q.wd_per == $past(q.arg_per))
		##1 (q.fsm == HWO_S_IDLE))
		else $error("watchdog setting not stored");

	safe_force_a: assert property ( // RULE9
		(HAS_OUT && $rose(q.alarm)) |-> q.dout == $past(q.safe))
		else $error("outputs not forced to the safe byte");

	pon_capture_a: assert property ( // RULE12
		(HAS_OUT && exec_w && q.op == HWO_OP_PON_CAPTURE) |=> q.pon == $past(q.dout))
		else $error("power-on byte not captured");

	safe_capture_a: assert property ( // RULE13
		(HAS_OUT && exec_w && q.op == HWO_OP_SAFE_CAPTURE) |=> q.safe == $past(q.dout))
		else $error("safe byte not captured");

	strap_default_a: assert property ( // RULE16
		(q.strap_done && q.strap) |->
		(q.eff_addr == `HWO_DEF_ADDR && q.eff_baud == `HWO_DEF_BAUD && !q.eff_chk))
		else $error("strap did not force defaults");

	module_reset_a: assert property ( // RULE20
		q.cpu_rst |-> (q.rst_flag && q.dout == $past(q.pon, 1)) || $past(expire_w))
		else $error("module watchdog reset missed flag or outputs");

	alive_silent_a: assert property ( // RULE24
		(exec_w && q.op == HWO_OP_HOST_ALIVE) |=> (q.rkind == HWO_RK_NONE && q.kick))
		else $error("host-alive answered or not passed on");

	disabled_quiet_a: assert property ( // RULE26
		(!q.wd_en && !$past(q.wd_en)) |-> !expire_w)
		else $error("alarm raised with watchdog disabled");

endmodule
`default_nettype wire

// ==== sim/hwo_host.sv ====
/*
 Host-side partner: an APB master that posts framed host commands into the
 block. Assumes pclk comes from the bench and the bench calls xfer.
*/
`timescale 1ns/1ns
`default_nettype none

module hwo_host (
	input  wire logic        pclk,    // Clock
	output logic             psel,    // APB select
	output logic             penable, // APB access phase
	output logic             pwrite,  // APB write
	output logic [7:0]       paddr,   // APB byte address
	output logic [31:0]      pwdata,  // APB write data
	input  wire logic [31:0] prdata,  // APB read data
	input  wire logic        pready,  // APB ready
	input  wire logic        pslverr  // APB error
);
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	// One transfer, held until pready is sampled high; idle data is inverted
	// afterwards so a stale word never passes for a fresh one
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Waits as long as the slave needs; only the bench ceiling ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
		@(posedge pclk);
	endtask
endmodule

`default_nettype wire

// ==== sim/hwo_top_tb.sv ====
/*
 Self-checking bench of the host-watchdog and output-safety block.
 Assumes the hwo_host APB master and short tick and restart counts.
*/
`timescale 1ns/1ns
`default_nettype none
`include "hwo_defines.svh"

module hwo_top_tb;
	import hwo_pkg::*;
	localparam int TICK = 8;
	localparam int MWD  = 400;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        init_strap_n, eff_chk, alarm_out, cpu_reset_pulse, errv;
	logic [7:0]  paddr, pins, digital_out, eff_addr, eff_baud, exp_addr, v, p;
	logic [31:0] pwdata, prdata, rdv, nm;
	logic [31:0] seed = 32'h0000000c;
	int          bad_count = 0;
	int          checked = 0;
	int          cyc = 0;
	int          n;

	hwo_top #(.TICK_CYC(TICK), .MWD_CYC(MWD)) i_hwo_top (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .input_channel_pin(pins),
		.init_strap_n(init_strap_n), .digital_out(digital_out),
		.cpu_reset_pulse(cpu_reset_pulse), .eff_addr(eff_addr), .eff_baud(eff_baud),
		.eff_chk(eff_chk), .alarm_out(alarm_out));
	hwo_host i_hwo_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	// Clock, and a ceiling that cuts a hang short
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			end_of_test();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input string nmx, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nmx, exp, seen);
		end
	endtask

	task automatic rd(input logic [7:0] a);
		i_hwo_host.xfer(1'b0, a, 32'h00000000, rdv, errv);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_hwo_host.xfer(1'b1, a, d, rdv, errv);
	endtask

	// Refresh the module watchdog, post a command, await the reply, fetch payload
	task automatic cmd(input logic [3:0] op, input logic [2:0] fl, input logic [7:0] per,
		input hwo_rkind_t k);
		int c;
		c = 0;
		wr(`HWO_A_KICK, 32'h00000001);
		wr(`HWO_A_CMD, {16'h0000, per, 1'b0, fl, op});
		do begin
			rd(`HWO_A_REPLY);
			c++;
		end while (rdv[2] !== 1'b1 && c < 8);
		chk("reply kind", {30'h0, rdv[1:0]}, {30'h0, k});
		if (k == HWO_RK_VALID) chk("reply addr", {24'h0, rdv[15:8]}, {24'h0, exp_addr});
		rd(`HWO_A_RDATA);
	endtask

	task automatic do_reset(input logic strap);
		presetn <= 1'b0;
		init_strap_n <= strap;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask

	task automatic end_of_test();
		if (bad_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		presetn = 1'b0;
		init_strap_n = 1'b1;
		pins = 8'h00;
		do_reset(1'b1);
		exp_addr = `HWO_RST_ADDR;
		chk("dout power-up", {24'h0, digital_out}, {24'h0, `HWO_RST_PON});
		rd(`HWO_A_STAT);
		chk("reset flag", {31'h0, rdv[10]}, 32'h00000001);
		cmd(4'hb, 3'h0, 8'h00, HWO_RK_VALID);
		chk("readback", rdv, 32'h00000001);
		// Inputs: a closed contact pulls its pin low
		nm = rnd();
		pins <= nm[7:0];
		@(posedge pclk);
		rd(`HWO_A_DIN);
		chk("inputs", rdv, {24'h0, ~pins});
		// Capture safe and power-on bytes from the present outputs
		nm = rnd();
		v = nm[7:0];
		p = nm[15:8];
		wr(`HWO_A_DOUT, {24'h0, v});
		cmd(4'h8, 3'h0, 8'h00, HWO_RK_VALID);
		wr(`HWO_A_DOUT, {24'h0, p});
		cmd(4'h7, 3'h0, 8'h00, HWO_RK_VALID);
		cmd(4'h6, 3'h0, 8'h00, HWO_RK_VALID);
		chk("safe read", rdv, {16'h0, v, 8'h00});
		cmd(4'h5, 3'h0, 8'h00, HWO_RK_VALID);
		chk("pon read", rdv, {16'h0, p, 8'h00});
		wr(`HWO_A_DOUT, {24'h0, ~v});
		// Four characters, random
		nm = rnd();
		wr(`HWO_A_ARG, nm);
		cmd(4'h9, 3'h0, 8'h00, HWO_RK_VALID);
		cmd(4'ha, 3'h0, 8'h00, HWO_RK_VALID);
		chk("name", rdv, nm);
		// Unknown code, malformed frame, line error, unmapped address
		cmd(4'hf, 3'h0, 8'h00, HWO_RK_INVALID);
		cmd(4'h1, 3'h4, 8'h00, HWO_RK_INVALID);
		cmd(4'h1, 3'h2, 8'h00, HWO_RK_NONE);
		rd(8'h30);
		chk("unmapped", {errv, rdv[30:0]}, 32'h80000000);
		// Host watchdog at eight ticks: room for the read-back command before
		// the first broadcast, which the host owes before the period ends
		cmd(4'h4, 3'h1, 8'h08, HWO_RK_VALID);
		cmd(4'h3, 3'h0, 8'h00, HWO_RK_VALID);
		chk("wd read", rdv, 32'h00000108);
		repeat (12) wr(`HWO_A_CMD, 32'h0000000d);
		chk("alive no alarm", {31'h0, alarm_out}, 32'h0);
		n = 0;
		while (alarm_out !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		chk("alarm delay", {31'h0, n >= 8 * TICK && n <= 8 * TICK + 6}, 32'h1);
		chk("safe outputs", {24'h0, digital_out}, {24'h0, v});
		rd(`HWO_A_STAT);
		chk("stat code", {24'h0, rdv[7:0]}, {24'h0, `HWO_CODE_ALARM});
		cmd(4'h1, 3'h0, 8'h00, HWO_RK_VALID);
		chk("status alarm", rdv, {24'h0, `HWO_CODE_ALARM});
		cmd(4'h4, 3'h0, 8'h03, HWO_RK_VALID);
		cmd(4'h2, 3'h0, 8'h00, HWO_RK_VALID);
		cmd(4'h1, 3'h0, 8'h00, HWO_RK_VALID);
		chk("status normal", rdv, {24'h0, `HWO_CODE_NORMAL});
		repeat (100) @(posedge pclk);
		chk("disabled quiet", {31'h0, alarm_out}, 32'h0);
		// Refresh once, then stop: the module watchdog restarts the processor
		nm = rnd();
		wr(`HWO_A_KICK, 32'h00000001);
		wr(`HWO_A_DOUT, nm);
		n = 0;
		while (cpu_reset_pulse !== 1'b1 && n < MWD + 50) begin
			@(posedge pclk);
			n++;
		end
		chk("restart", {31'h0, n >= MWD - 60 && n < MWD + 10}, 32'h1);
		@(posedge pclk);
		chk("default outputs", {24'h0, digital_out}, {24'h0, p});
		cmd(4'hb, 3'h0, 8'h00, HWO_RK_VALID);
		chk("restart flag", rdv, 32'h00000001);
		wr(`HWO_A_DOUT, nm);
		chk("outputs resent", {24'h0, digital_out}, {24'h0, nm[7:0]});
		// Strapped power-up uses defaults but still reports the stored set
		do_reset(1'b0);
		exp_addr = `HWO_DEF_ADDR;
		chk("strap cfg", {eff_chk, eff_baud, eff_addr},
			{`HWO_DEF_CHK, `HWO_DEF_BAUD, `HWO_DEF_ADDR});
		cmd(4'hc, 3'h0, 8'h00, HWO_RK_VALID);
		chk("stored cfg", rdv, {15'h0, 1'b0, `HWO_RST_BAUD, `HWO_RST_ADDR});
		do_reset(1'b1);
		chk("released cfg", {eff_chk, eff_baud, eff_addr},
			{1'b0, `HWO_RST_BAUD, `HWO_RST_ADDR});
		end_of_test();
	end
endmodule

`default_nettype wire
